// ### hw/ssp_pkg.sv
/*
 strap sampling and pad mux: shared constants.
 assumes a 200 MHz core clock and a 32-bit apb register port.
*/
// Functional notes
// - the strap pins are sampled at power-on reset and the mode selections come from them.
// - the sample is taken a few milliseconds after reset release, not at the reset edge.
// - after sampling every strap pin returns to its normal gpio or alternate function.
// - each strap pin carries a pull that sets its default value when left open.
// - host data line two defaults to 1 for sdio; held low it selects the generic serial host.
// - jtag can be routed to the sdio pads or to the voice sample port pads.
// - with debug select low, lines two and one give normal, jtag on sdio, jtag on voice, swd.
// - both power enable inputs keep a 200k pull-down, which software may drop in active or sleep.
// - clock request is active high, programmable drive when active, open drain otherwise, pulled down off.
// - both wake lines have programmable pulls; host wakeup drives low when only the radio is up.
// - with both power enables low the keeper pads float with no pull.
// - a low power enable holds its section in reset.
package ssp_pkg;
   // timing
   localparam int CLK_MHZ = 200;
   localparam int STRAP_DELAY_US = 2000;
   localparam int STRAP_DELAY_CYC = STRAP_DELAY_US * CLK_MHZ;
   localparam int CNT_W = 20;
   // register map, byte addresses
   localparam logic [11:0] CTRL_OFS = 12'h000;
   localparam logic [11:0] STATUS_OFS = 12'h004;
   // control fields
   localparam int CTRL_APPLY = 0;
   localparam int CTRL_WLAN_PD_OFF = 1;
   localparam int CTRL_RADIO_PD_OFF = 2;
   localparam int CTRL_CLKREQ_PP = 3;
   localparam int CTRL_HWAKE_LSB = 4;
   localparam int CTRL_DWAKE_LSB = 6;
   localparam logic [7:0] CTRL_RESET = 8'h00;
   // status fields
   localparam int STAT_DONE = 4;
   localparam int STAT_HOST_SPI = 5;
   localparam int STAT_DBG_LSB = 6;
   localparam int STAT_WLAN_ON = 8;
   localparam int STAT_RADIO_ON = 9;
   // strap vector positions and defaults: data2, gpio1, gpio2, debug select
   localparam int ST_DATA2 = 0;
   localparam int ST_GPIO1 = 1;
   localparam int ST_GPIO2 = 2;
   localparam int ST_DSEL = 3;
   localparam logic [3:0] STRAP_DEFAULT = 4'h1;
   localparam logic [3:0] STRAP_PU = 4'h1;
   localparam logic [3:0] STRAP_PD = 4'hE;
   // pull modes
   typedef enum logic [1:0] {
      SSP_PULL_NONE, SSP_PULL_UP, SSP_PULL_DOWN, SSP_PULL_NONE2
   } ssp_pull_t;
   typedef enum logic [1:0] {
      SSP_DBG_NORMAL, SSP_DBG_JTAG_SDIO, SSP_DBG_JTAG_VOICE, SSP_DBG_SWD
   } ssp_dbg_t;
endpackage

// ### hw/ssp_pull.sv
/*
 pull selection for one programmable keeper pad.
 assumes the caller resolves the power state.
*/
`timescale 1ns/10ps
`default_nettype none
module ssp_pull (
   input wire logic [1:0] mode_i,
   input wire logic apply_i,
   input wire logic off_i,
   input wire logic dflt_pd_i,
   output logic pu_o,
   output logic pd_o
);
   wire prog_up = (mode_i == ssp_pkg::SSP_PULL_UP);
   wire prog_dn = (mode_i == ssp_pkg::SSP_PULL_DOWN);
   // power-down floats the pad; otherwise program or fall back to default
   assign pu_o = !off_i && apply_i && prog_up;
   assign pd_o = !off_i && (apply_i ? prog_dn : dflt_pd_i);
endmodule // ssp_pull
`default_nettype wire

// ### hw/ssp_strap_mux.sv
/*
 strap capture, debug pad mux and per-power-state pad control, apb regs.
 assumes pad cells outside turn oe/out/pu/pd into the wire level and that
 all pad inputs are asynchronous to mclk_i.
*/
`timescale 1ns/10ps
`default_nettype none
module ssp_strap_mux #(
   parameter int SAMPLE_DELAY_CYC = ssp_pkg::STRAP_DELAY_CYC
) (
   input wire logic mclk_i,
   input wire logic rstn_i,
   // apb
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [11:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   output logic [31:0] prdata_o,
   output logic pready_o,
   output logic pslverr_o,
   // pins
   input wire logic ext_por_n_i,
   input wire logic wlan_power_enable_i,
   input wire logic radio_power_enable_i,
   input wire logic [3:0] strap_pin_i,
   // strap pad pulls and function switch
   output logic [3:0] strap_pu_o,
   output logic [3:0] strap_pd_o,
   output logic strap_func_o,
   // captured modes
   output logic host_spi_o,
   output logic sdio_jtag_o,
   output logic voice_jtag_o,
   output logic swd_gpio_o,
   // power enable pulls and section resets
   output logic wlan_power_enable_pd_o,
   output logic radio_power_enable_pd_o,
   output logic wlan_rst_n_o,
   output logic radio_rst_n_o,
   // clock request pad
   input wire logic clk_req_i,
   output logic clk_req_o,
   output logic clk_req_oe_o,
   output logic clk_req_pd_o,
   // wake pads
   input wire logic radio_host_wakeup_i,
   output logic radio_host_wakeup_o,
   output logic radio_host_wakeup_oe_o,
   output logic radio_host_wakeup_pu_o,
   output logic radio_host_wakeup_pd_o,
   output logic radio_device_wakeup_pu_o,
   output logic radio_device_wakeup_pd_o,
   // uart flow control pads
   input wire logic radio_uart_request_i,
   output logic radio_uart_request_out_o,
   output logic radio_uart_request_out_oe_o,
   output logic radio_uart_request_out_pu_o,
   output logic radio_uart_clear_in_pu_o
);
   localparam logic [ssp_pkg::CNT_W-1:0] DELAY_LAST =
      ssp_pkg::CNT_W'(SAMPLE_DELAY_CYC - 1);

   logic [6:0] pins_s;
   logic [7:0] ctrl;
   logic [3:0] strap;
   logic [1:0] dbg;
   logic done;
   logic [ssp_pkg::CNT_W-1:0] cnt;

   ssp_sync #(
      .W(7)
   ) u_sync (
      .mclk_i(mclk_i),
      .rstn_i(rstn_i),
      .d_i({ext_por_n_i, radio_power_enable_i, wlan_power_enable_i,
            strap_pin_i}),
      .q_o(pins_s)
   );

   wire [3:0] strap_s = pins_s[3:0];
   wire wl_on = pins_s[4];
   wire bt_on = pins_s[5];
   wire por_ok = pins_s[6];

   // power states
   wire pwr_off = !wl_on && !bt_on;
   wire radio_only = !wl_on && bt_on;
   wire wlan_only = wl_on && !bt_on;
   wire both_on = wl_on && bt_on;
   // active/sleep: all power present and firmware has set up the pads
   wire active = both_on && ctrl[ssp_pkg::CTRL_APPLY];

   // capture timing
   wire cnt_hit = (cnt == DELAY_LAST);
   wire take = por_ok && !done && cnt_hit;
   wire [ssp_pkg::CNT_W-1:0] next_cnt =
      (!por_ok || done) ? '0 : cnt + ssp_pkg::CNT_W'(1);

   wire [1:0] next_dbg = strap_s[ssp_pkg::ST_DSEL] ? ssp_pkg::SSP_DBG_NORMAL :
      {strap_s[ssp_pkg::ST_GPIO2], strap_s[ssp_pkg::ST_GPIO1]};

   always_ff @(posedge mclk_i) begin
      if (!rstn_i) begin
         cnt <= '0;
      end else begin
         cnt <= next_cnt;
      end
   end

   always_ff @(posedge mclk_i) begin
      if (!rstn_i || !por_ok) begin
         done <= 1'b0;
         strap <= ssp_pkg::STRAP_DEFAULT;
         dbg <= ssp_pkg::SSP_DBG_NORMAL;
      end else if (take) begin
         done <= 1'b1;
         strap <= strap_s;
         dbg <= next_dbg;
      end
   end

   // sdio unless data line two sampled low
   assign host_spi_o = !strap[ssp_pkg::ST_DATA2];
   assign sdio_jtag_o = (dbg == ssp_pkg::SSP_DBG_JTAG_SDIO);
   assign voice_jtag_o = (dbg == ssp_pkg::SSP_DBG_JTAG_VOICE);
   assign swd_gpio_o = (dbg == ssp_pkg::SSP_DBG_SWD);

   assign strap_pu_o = done ? 4'h0 : ssp_pkg::STRAP_PU;
   // debug select keeps its pull-down in every powered state
   assign strap_pd_o = done ? {!pwr_off, 3'h0} : ssp_pkg::STRAP_PD;
   // pins take their function once sampled
   assign strap_func_o = done;

   // apb slave: zero wait states
   wire sel_ctrl = (paddr_i == ssp_pkg::CTRL_OFS);
   wire sel_stat = (paddr_i == ssp_pkg::STATUS_OFS);
   wire mapped = sel_ctrl || sel_stat;
   wire acc = psel_i && penable_i;
   wire wr_ctrl = acc && pwrite_i && sel_ctrl;
   wire [31:0] stat_word = {22'h0, bt_on, wl_on, dbg, host_spi_o, done,
      strap};
   assign pready_o = 1'b1;
   assign pslverr_o = acc && !mapped;
   assign prdata_o = !acc ? 32'h0 : sel_ctrl ? {24'h0, ctrl} :
      sel_stat ? stat_word : 32'h0;

   always_ff @(posedge mclk_i) begin
      if (!rstn_i) begin
         ctrl <= ssp_pkg::CTRL_RESET;
      end else if (wr_ctrl) begin
         ctrl <= pwdata_i[7:0];
      end
   end

   // sections held in reset while unpowered
   assign wlan_rst_n_o = wl_on;
   assign radio_rst_n_o = bt_on;

   // pull-down stays unless dropped while active
   assign wlan_power_enable_pd_o =
      !(active && ctrl[ssp_pkg::CTRL_WLAN_PD_OFF]);
   assign radio_power_enable_pd_o =
      !(active && ctrl[ssp_pkg::CTRL_RADIO_PD_OFF]);

   wire cr_pp = active && ctrl[ssp_pkg::CTRL_CLKREQ_PP];
   assign clk_req_o = clk_req_i && !pwr_off;
   assign clk_req_oe_o = !pwr_off && (cr_pp || !clk_req_i);
   assign clk_req_pd_o = pwr_off;

   ssp_pull u_hwake (
      .mode_i(ctrl[ssp_pkg::CTRL_HWAKE_LSB +: 2]),
      .apply_i(active),
      .off_i(pwr_off || radio_only),
      .dflt_pd_i(1'b1),
      .pu_o(radio_host_wakeup_pu_o),
      .pd_o(radio_host_wakeup_pd_o)
   );
   ssp_pull u_dwake (
      .mode_i(ctrl[ssp_pkg::CTRL_DWAKE_LSB +: 2]),
      .apply_i(active),
      .off_i(pwr_off),
      .dflt_pd_i(1'b1),
      .pu_o(radio_device_wakeup_pu_o),
      .pd_o(radio_device_wakeup_pd_o)
   );
   // host wakeup driven low when only the radio is up
   assign radio_host_wakeup_oe_o = radio_only || active;
   assign radio_host_wakeup_o = active && radio_host_wakeup_i;

   // uart flow control: floats when unpowered
   assign radio_uart_request_out_oe_o = !pwr_off && !wlan_only;
   assign radio_uart_request_out_o =
      radio_uart_request_out_oe_o && radio_uart_request_i;
   assign radio_uart_request_out_pu_o = wlan_only;
   assign radio_uart_clear_in_pu_o = wlan_only;

   // checks
   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (!rstn_i);

   a_capture_delay: assert property (
      $rose(por_ok) |-> !done [*2]
   ) else $error("straps taken too early");
   a_capture_value: assert property (
      take |=> (strap == $past(strap_s))
   ) else $error("captured straps differ from pins");
   a_strap_hold: assert property (
      (done && por_ok) |=> $stable(strap) && $stable(dbg)
   ) else $error("straps changed after capture");
   a_func_switch: assert property (
      done |-> (strap_func_o && strap_pu_o == 4'h0)
   ) else $error("strap pin still in strap mode");
   a_data2_pullup: assert property (
      !done |-> strap_pu_o[ssp_pkg::ST_DATA2] && !strap_pd_o[0]
   ) else $error("data line two default pull wrong");
   a_host_select: assert property (
      take |=> (host_spi_o == !$past(strap_s[ssp_pkg::ST_DATA2]))
   ) else $error("host interface select wrong");
   a_dbg_onehot: assert property (
      $onehot0({sdio_jtag_o, voice_jtag_o, swd_gpio_o})
   ) else $error("two debug paths at once");
   a_dbg_decode: assert property (
      (take && !strap_s[ssp_pkg::ST_DSEL]) |=>
         (swd_gpio_o == ($past(strap_s[2:1]) == 2'b11))
   ) else $error("debug mode decode wrong");
   a_en_pulldown: assert property (
      !active |-> (wlan_power_enable_pd_o && radio_power_enable_pd_o)
   ) else $error("enable pull-down dropped outside active");
   a_clkreq_drive: assert property (
      (!active && !pwr_off) |-> !(clk_req_oe_o && clk_req_o)
   ) else $error("clock request driven high while open drain");
   a_hwake_low: assert property (
      radio_only |-> (radio_host_wakeup_oe_o && !radio_host_wakeup_o)
   ) else $error("host wakeup not held low");
   a_off_float: assert property (
      pwr_off |-> !(radio_host_wakeup_oe_o || radio_host_wakeup_pu_o ||
         radio_device_wakeup_pd_o || radio_uart_request_out_oe_o ||
         radio_uart_clear_in_pu_o)
   ) else $error("keeper pad not floating in power-down");
   a_sect_reset: assert property (
      !wl_on |-> !wlan_rst_n_o
   ) else $error("wlan section not held in reset");
   a_radio_reset: assert property (
      !bt_on |-> !radio_rst_n_o
   ) else $error("radio section not held in reset");
   // the open pad pulls are the only thing defining the sampled level
   a_strap_idle_pulls: assert property (
      !done |-> (strap_pu_o == ssp_pkg::STRAP_PU &&
         strap_pd_o == ssp_pkg::STRAP_PD)
   ) else $error("strap pulls wrong while sampling");
   a_capture_once: assert property (
      (done && por_ok) |=> done
   ) else $error("capture flag lost without reset");
   a_dbg_sdio: assert property (
      (take && !strap_s[ssp_pkg::ST_DSEL]) |=>
         (sdio_jtag_o == ($past(strap_s[2:1]) == 2'b01))
   ) else $error("jtag on sdio decode wrong");
   a_dbg_voice: assert property (
      (take && !strap_s[ssp_pkg::ST_DSEL]) |=>
         (voice_jtag_o == ($past(strap_s[2:1]) == 2'b10))
   ) else $error("jtag on voice decode wrong");
   // debug select high is treated as normal mode; no documented meaning
   a_dsel_normal: assert property (
      (take && strap_s[ssp_pkg::ST_DSEL]) |=>
         !(sdio_jtag_o || voice_jtag_o || swd_gpio_o)
   ) else $error("debug path with select high");
   a_en_pd_off: assert property (
      pwr_off |-> (wlan_power_enable_pd_o && radio_power_enable_pd_o)
   ) else $error("enable pull-down missing in power-down");
   a_clkreq_off: assert property (
      pwr_off |-> (clk_req_pd_o && !clk_req_oe_o && !clk_req_o)
   ) else $error("clock request not pulled down when off");
   a_clkreq_pd_on: assert property (
      !pwr_off |-> !clk_req_pd_o
   ) else $error("clock request pull-down while powered");
   // wlan-only keeps host wakeup an input so the host sees no glitch
   a_hwake_wlan: assert property (
      wlan_only |-> (radio_host_wakeup_pd_o && !radio_host_wakeup_oe_o)
   ) else $error("host wakeup not pulled down in wlan only");
   a_uart_wlan: assert property (
      wlan_only |-> (radio_uart_request_out_pu_o &&
         radio_uart_clear_in_pu_o && !radio_uart_request_out_oe_o)
   ) else $error("uart pads wrong in wlan only");
   a_uart_radio: assert property (
      radio_only |-> (radio_uart_request_out_oe_o &&
         !radio_uart_request_out_pu_o && !radio_uart_clear_in_pu_o)
   ) else $error("uart request not driven in radio only");
endmodule // ssp_strap_mux
`default_nettype wire

// ### hw/ssp_sync.sv
/*
 two-flop synchroniser for a vector of pin levels.
 assumes the inputs are quasi-static pad levels.
*/
`timescale 1ns/10ps
`default_nettype none
module ssp_sync #(
   parameter int W = 1
) (
   input wire logic mclk_i,
   input wire logic rstn_i,
   input wire logic [W-1:0] d_i,
   output logic [W-1:0] q_o
);
   logic [W-1:0] meta;
   always_ff @(posedge mclk_i) begin
      if (!rstn_i) begin
         meta <= '0;
         q_o <= '0;
      end else begin
         meta <= d_i;
         q_o <= meta;
      end
   end
endmodule // ssp_sync
`default_nettype wire

// ### tb/ssp_board.sv
/*
 board strap resistors seen by the strap pads.
 assumes the bench sets which straps the board holds and to what level.
*/
`timescale 1ns/10ps
`default_nettype none
module ssp_board (
   input wire logic mclk_i,
   input wire logic [3:0] drv_en_i,
   input wire logic [3:0] drv_val_i,
   input wire logic [3:0] strap_pu_i,
   input wire logic [3:0] strap_pd_i,
   output logic [3:0] strap_pin_o
);
   // an unpulled, undriven pad must not look like a clean level
   logic [3:0] float_pat = 4'h5;
   always @(posedge mclk_i) begin
      float_pat <= ~float_pat;
   end
   always_comb begin
      for (int i = 0; i < 4; i++) begin
         if (drv_en_i[i]) strap_pin_o[i] = drv_val_i[i];
         else if (strap_pu_i[i]) strap_pin_o[i] = 1'b1;
         else if (strap_pd_i[i]) strap_pin_o[i] = 1'b0;
         else strap_pin_o[i] = float_pat[i];
      end
   end
endmodule // ssp_board
`default_nettype wire

// ### tb/strap_sampling_pad_mux_tb.sv
/*
 self-checking bench for the strap sampler and pad mux.
 assumes a zero-wait apb slave and a short strap delay of 8 cycles.
*/
`timescale 1ns/10ps
`default_nettype none
module strap_sampling_pad_mux_tb;
   logic mclk_i = 0, rstn_i = 0, psel = 0, penable = 0, pwrite = 0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, rd, st;
   logic pready, pslverr, err, ext_por_n = 1, wl_en = 0, rd_en = 0;
   logic clk_req = 0, hw_in = 0, urq_in = 0;
   logic [3:0] drv_en = 4'h0, drv_val = 4'h0, pins, spu, spd;
   logic func, hspi, sjt, vjt, swd, wpd, rpd, wrst, rrst, cro, croe, crpd;
   logic hwo, hwoe, hwpu, hwpd, dwpu, dwpd, uro, uroe, urpu, ucpu;
   int n_mismatch = 0, n_checks = 0;
   always #2.5 mclk_i = ~mclk_i;
   ssp_board u_board (.mclk_i(mclk_i), .drv_en_i(drv_en), .drv_val_i(drv_val),
      .strap_pu_i(spu), .strap_pd_i(spd), .strap_pin_o(pins));
   ssp_strap_mux #(.SAMPLE_DELAY_CYC(8)) u_dut (.mclk_i(mclk_i),
      .rstn_i(rstn_i), .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
      .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
      .pready_o(pready), .pslverr_o(pslverr), .ext_por_n_i(ext_por_n),
      .wlan_power_enable_i(wl_en), .radio_power_enable_i(rd_en),
      .strap_pin_i(pins), .strap_pu_o(spu), .strap_pd_o(spd),
      .strap_func_o(func), .host_spi_o(hspi), .sdio_jtag_o(sjt),
      .voice_jtag_o(vjt), .swd_gpio_o(swd), .wlan_power_enable_pd_o(wpd),
      .radio_power_enable_pd_o(rpd), .wlan_rst_n_o(wrst),
      .radio_rst_n_o(rrst), .clk_req_i(clk_req), .clk_req_o(cro),
      .clk_req_oe_o(croe), .clk_req_pd_o(crpd), .radio_host_wakeup_i(hw_in),
      .radio_host_wakeup_o(hwo), .radio_host_wakeup_oe_o(hwoe),
      .radio_host_wakeup_pu_o(hwpu), .radio_host_wakeup_pd_o(hwpd),
      .radio_device_wakeup_pu_o(dwpu), .radio_device_wakeup_pd_o(dwpd),
      .radio_uart_request_i(urq_in), .radio_uart_request_out_o(uro),
      .radio_uart_request_out_oe_o(uroe),
      .radio_uart_request_out_pu_o(urpu), .radio_uart_clear_in_pu_o(ucpu));

   task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                      input string msg);
      n_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("CHECK FAILED %0t %s", $time, msg);
      end
   endtask

   // one apb transfer; request held until pready is seen high
   task automatic apb(input logic wr, input logic [11:0] a,
                      input logic [31:0] wd);
      int n;
      n = 0;
      @(posedge mclk_i);
      psel <= 1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge mclk_i);
      penable <= 1;
      do begin
         @(posedge mclk_i);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (n >= 50) chk(0, 1, "apb no ready");
      rd = prdata;
      err = pslverr;
      psel <= 0;
      penable <= 0;
   endtask

   task automatic wait_done();
      int n;
      n = 0;
      while (func !== 1'b1 && n < 100) begin
         @(posedge mclk_i);
         n++;
      end
      chk(func, 1, "straps not captured");
   endtask

   task automatic complete_run();
      $display("checks %0d mismatches %0d", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask

   initial begin
      repeat (5000) @(posedge mclk_i);
      n_mismatch++;
      complete_run();
   end

   initial begin
      repeat (20) @(posedge mclk_i);
      rstn_i <= 1;
      repeat (4) @(posedge mclk_i);
      chk(crpd, 1, "clk request not pulled down off");
      chk({hwoe, hwpu, hwpd, dwpu, dwpd, uroe, urpu, ucpu}, 0, "pads off");
      chk({wrst, rrst}, 0, "sections not held in reset");
      chk({spu, spd}, 8'h1E, "strap pulls while sampling");
      wait_done();
      chk({hspi, sjt, vjt, swd}, 0, "open straps not sdio normal");
      chk({spu, spd}, 8'h00, "strap pulls after capture");
      apb(0, ssp_pkg::STATUS_OFS, 0);
      chk(rd[5:0], 6'h11, "status after default capture");
      st = rd;
      $display("test default straps done");
      for (int m = 0; m < 4; m++) begin
         drv_en <= 4'hF;
         drv_val <= {1'b0, m[1], m[0], 1'b0};
         ext_por_n <= 0;
         repeat (4) @(posedge mclk_i);
         ext_por_n <= 1;
         repeat (5) @(posedge mclk_i);
         chk(func, 0, "captured at reset edge");
         wait_done();
         chk({hspi, swd, vjt, sjt}, {1'b1, 3'(m == 0 ? 0 : 1 << (m - 1))},
             "debug route");
      end
      drv_val <= 4'hF;
      repeat (10) @(posedge mclk_i);
      chk({hspi, swd, vjt, sjt}, 4'hC, "captured straps moved");
      $display("test debug modes done");
      rd_en <= 1;
      urq_in <= 1;
      repeat (4) @(posedge mclk_i);
      chk({hwoe, hwo, wrst, rrst}, 4'h9, "radio only state");
      chk({uroe, uro, urpu, ucpu}, 4'hC, "radio only uart");
      wl_en <= 1;
      clk_req <= 1;
      hw_in <= 1;
      apb(1, ssp_pkg::CTRL_OFS, 32'h0000009F);
      repeat (4) @(posedge mclk_i);
      chk({wpd, rpd, crpd}, 0, "pulls not dropped when active");
      chk({croe, cro}, 2'h3, "push-pull clock request");
      chk({hwpu, hwpd, dwpu, dwpd}, 4'h9, "wake pulls");
      chk({hwoe, hwo}, 2'h3, "host wakeup driven when active");
      chk(spd, 4'h8, "debug select pull when powered");
      apb(0, ssp_pkg::CTRL_OFS, 0);
      chk(rd, 32'h9F, "ctrl readback");
      apb(1, ssp_pkg::CTRL_OFS, 32'h00000001);
      repeat (4) @(posedge mclk_i);
      chk({wpd, rpd}, 2'h3, "default 200k pull-down");
      rd_en <= 0;
      repeat (4) @(posedge mclk_i);
      chk({uroe, urpu, ucpu, hwoe, hwpd, rrst, wrst}, 7'h35, "wlan only");
      chk({croe, cro, crpd}, 3'h2, "open drain clock request");
      $display("test power states done");
      apb(0, 12'h008, 0);
      chk({err, rd}, {1'b1, 32'h0}, "unmapped read");
      apb(1, ssp_pkg::STATUS_OFS, 32'hFFFFFFFF);
      apb(0, ssp_pkg::STATUS_OFS, 0);
      chk(rd, 32'h000001F6, "status changed by write");
      wl_en <= 0;
      rd_en <= 0;
      repeat (4) @(posedge mclk_i);
      chk({hwoe, hwpu, hwpd, dwpu, dwpd, uroe, urpu, ucpu}, 0, "pads off");
      chk({crpd, wrst, rrst}, 3'h4, "power down state");
      $display("test register and off state done");
      complete_run();
   end
endmodule // strap_sampling_pad_mux_tb
`default_nettype wire
